// ### hdl/phy_irq_pkg.sv
// Purpose: Shared constants and types for the PHY interrupt block
// Assumes: 5-bit register index, 16-bit register data
// Notes:   Flag vectors are indexed 7 down to 1
// Function
// - Reset-only bits clear on port PHY reset
// - Only when soft reset bit is set
// - Crossover decode: 00 straight, 01 cross, 10 auto
// - Flags read-only, latch high until cleared
// - Source read returns flags then clears all but flags set that cycle
// - Bit 7 set on energy present rising
// - Bit 6 set on auto-negotiation done
// - Bit 5 set on remote fault
// - Bit 4 set on link down
// - Bit 3 set on partner acknowledge
// - Bit 2 set on parallel-detection fault
// - Bit 1 set on page received
// - Mask bits 7..1 enable same-position flags
// - All mask bits reset to zero
// - Crossover bits act only with override set
package phy_irq_pkg;
    // ==========================================================
    // Register map
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] REG_BASIC_IDX = 5'h00;
    localparam logic [4:0] REG_RSTCTL_IDX = 5'h10;
    localparam logic [4:0] REG_XOVER_IDX = 5'h1B;
    localparam logic [4:0] REG_SRC_IDX = 5'h1D;
    localparam logic [4:0] REG_MASK_IDX = 5'h1E;
    // ==========================================================
    // Field positions
    localparam int SOFT_RST_BIT = 15;
    localparam int PORT_RST_BIT = 1;
    localparam int XO_OVR_BIT = 15;
    localparam int XO_EN_BIT = 14;
    localparam int XO_ST_BIT = 13;
    localparam int FLAG_MSB = 7;
    localparam int FLAG_LSB = 1;
    localparam int ENERGY_BIT = 7;
    localparam int ANEG_DONE_BIT = 6;
    localparam int RFAULT_BIT = 5;
    localparam int LINK_DOWN_BIT = 4;
    localparam int ACK_BIT = 3;
    localparam int PDF_BIT = 2;
    localparam int PAGE_BIT = 1;
    // ==========================================================
    // Reset values and edge polarity (1 = falling edge event)
    localparam logic [7:1] MASK_RESET = 7'h00;
    localparam logic [7:1] FLAGS_RESET = 7'h00;
    localparam logic [7:1] EVT_FALL_SEL = 7'h08;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        XO_STRAIGHT = 3'b001,
        XO_CROSS = 3'b010,
        XO_AUTO = 3'b100
    } xover_mode_t;
    typedef struct packed {
        logic energy_present;
        logic autoneg_done;
        logic remote_fault;
        logic link_up;
        logic partner_ack;
        logic parallel_fault;
        logic page_received;
    } phy_events_t;
    typedef struct packed {
        logic strap_auto;
        logic strap_cross;
    } xover_strap_t;
endpackage

// ### hdl/event_detect.sv
// Purpose: Turns PHY status levels into one-cycle event pulses
// Assumes: Status levels come from logic on the same clock
// Notes:   Link down is a falling edge, all others rising
`timescale 1ns/1ps
module event_detect (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire phy_irq_pkg::phy_events_t events_i,
    output logic [7:1] pulse_o
);
    import phy_irq_pkg::*;
    typedef struct packed {
        logic [7:1] prev;
    } det_state_t;
    det_state_t s_reg;
    det_state_t s_next;
    logic [7:1] cur;

    assign cur = events_i;

    always_comb begin
        s_next = s_reg;
        s_next.prev = cur;
        pulse_o = (cur & ~s_reg.prev & ~EVT_FALL_SEL)
                | (~cur & s_reg.prev & EVT_FALL_SEL);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// ### hdl/crossover_decode.sv
// Purpose: Chooses the cable crossover mode
// Assumes: Strap levels are already synchronised
// Notes:   Reserved 11 setting falls back to automatic
`timescale 1ns/1ps
module crossover_decode (
    input wire logic override_i,
    input wire logic enable_i,
    input wire logic state_i,
    input wire phy_irq_pkg::xover_strap_t strap_i,
    output phy_irq_pkg::xover_mode_t mode_o
);
    import phy_irq_pkg::*;

    always_comb begin
        if (!override_i) begin
            if (strap_i.strap_auto) begin
                mode_o = XO_AUTO;
            end else if (strap_i.strap_cross) begin
                mode_o = XO_CROSS;
            end else begin
                mode_o = XO_STRAIGHT;
            end
        end else begin
            unique case ({enable_i, state_i})
                2'b00: begin
                    mode_o = XO_STRAIGHT;
                end
                2'b01: begin
                    mode_o = XO_CROSS;
                end
                default: begin
                    mode_o = XO_AUTO;
                end
            endcase
        end
    end
endmodule

// ### hdl/phy_irq_flags_and_crossover_ctrl.sv
// Purpose: Per-port PHY interrupt flags, mask and crossover control
// Assumes: Single-cycle strobes, read data one cycle after read
// Notes:   Strap pins are synchronised; PHY status is on-clock
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module phy_irq_flags_and_crossover_ctrl (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [phy_irq_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [phy_irq_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [phy_irq_pkg::DATA_W-1:0] RDATA_O,
    input wire phy_irq_pkg::phy_events_t EVENTS_I,
    input wire phy_irq_pkg::xover_strap_t STRAP_I,
    output logic IRQ_O,
    output logic PORT_RST_O,
    output phy_irq_pkg::xover_mode_t XOVER_MODE_O
);
    import phy_irq_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [15:0] rdata;
        logic [7:1] flags;
        logic [7:1] mask;
        logic xo_ovr;
        logic xo_en;
        logic xo_state;
        logic soft_rst;
        logic port_rst;
        logic irq;
        xover_mode_t mode;
        xover_strap_t strap_s1;
        xover_strap_t strap_s2;
    } ctl_state_t;

    ctl_state_t s_reg;
    ctl_state_t s_next;
    logic [7:1] evt_pulse;
    logic [7:1] set_vec;
    xover_mode_t mode_dec;
    logic rd_src;
    logic rd_mask;
    logic wr_mask;
    logic wr_xover;
    logic wr_basic;
    logic rst_req;

    // ==========================================================
    // Sub-blocks
    event_detect u_event_detect (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .events_i(EVENTS_I),
        .pulse_o(evt_pulse)
    );

    crossover_decode u_crossover_decode (
        .override_i(s_reg.xo_ovr),
        .enable_i(s_reg.xo_en),
        .state_i(s_reg.xo_state),
        .strap_i(s_reg.strap_s2),
        .mode_o(mode_dec)
    );

    // ==========================================================
    // Decode
    assign rd_src = RD_I && (ADDR_I == REG_SRC_IDX);
    assign rd_mask = RD_I && (ADDR_I == REG_MASK_IDX);
    assign wr_mask = WR_I && (ADDR_I == REG_MASK_IDX);
    assign wr_xover = WR_I && (ADDR_I == REG_XOVER_IDX);
    assign wr_basic = WR_I && (ADDR_I == REG_BASIC_IDX);
    assign rst_req = WR_I && (ADDR_I == REG_RSTCTL_IDX)
                   && WDATA_I[PORT_RST_BIT];
    assign set_vec = evt_pulse & s_reg.mask;

    // ==========================================================
    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.strap_s1 = STRAP_I;
        s_next.strap_s2 = s_reg.strap_s1;
        s_next.port_rst = 1'b0;
        s_next.rdata = DATA_ZERO;
        if (RD_I) begin
            unique case (ADDR_I)
                REG_BASIC_IDX: begin
                    s_next.rdata[SOFT_RST_BIT] = s_reg.soft_rst;
                end
                REG_XOVER_IDX: begin
                    s_next.rdata[XO_OVR_BIT] = s_reg.xo_ovr;
                    s_next.rdata[XO_EN_BIT] = s_reg.xo_en;
                    s_next.rdata[XO_ST_BIT] = s_reg.xo_state;
                end
                REG_SRC_IDX: begin
                    s_next.rdata[FLAG_MSB:FLAG_LSB] = s_reg.flags;
                end
                REG_MASK_IDX: begin
                    s_next.rdata[FLAG_MSB:FLAG_LSB] = s_reg.mask;
                end
                default: begin
                    s_next.rdata = DATA_ZERO;
                end
            endcase
        end
        if (wr_mask) begin
            s_next.mask = WDATA_I[FLAG_MSB:FLAG_LSB];
        end
        if (wr_xover) begin
            s_next.xo_ovr = WDATA_I[XO_OVR_BIT];
            s_next.xo_en = WDATA_I[XO_EN_BIT];
            s_next.xo_state = WDATA_I[XO_ST_BIT];
        end
        if (wr_basic) begin
            s_next.soft_rst = WDATA_I[SOFT_RST_BIT];
        end
        if (rst_req) begin
            s_next.port_rst = 1'b1;
            if (s_reg.soft_rst) begin
                s_next.xo_en = 1'b0;
                s_next.xo_state = 1'b0;
                s_next.soft_rst = 1'b0;
            end
        end
        // latch, clear on read, set wins
        s_next.flags = (s_reg.flags & ~{7{rd_src}}) | set_vec;
        s_next.irq = |(s_next.flags & s_next.mask);
        s_next.mode = mode_dec;
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s_reg <= '0;
            s_reg.flags <= FLAGS_RESET;
            s_reg.mask <= MASK_RESET;
            s_reg.mode <= XO_STRAIGHT;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs
    assign RDATA_O = s_reg.rdata;
    assign IRQ_O = s_reg.irq;
    assign PORT_RST_O = s_reg.port_rst;
    assign XOVER_MODE_O = s_reg.mode;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    a_read_returns_flags: assert property (
        rd_src |=> (RDATA_O[FLAG_MSB:FLAG_LSB] == $past(s_reg.flags))
    ) else $error("source read returned wrong flags");

    a_read_clears_flags: assert property (
        rd_src |=> (s_reg.flags == $past(set_vec))
    ) else $error("source read did not clear flags");

    a_flags_hold_high: assert property (
        !rd_src |=> ((s_reg.flags & $past(s_reg.flags))
                     == $past(s_reg.flags))
    ) else $error("flag dropped without a read");

    a_set_only_enabled: assert property (
        1'b1 |=> ((s_reg.flags & ~$past(s_reg.flags)
                   & ~$past(set_vec)) == 7'h00)
    ) else $error("flag set without enabled event");

    a_set_beats_clear: assert property (
        (rd_src && (|set_vec)) |=>
            ((s_reg.flags & $past(set_vec)) == $past(set_vec))
    ) else $error("event lost during clearing read");

    a_energy_event: assert property (
        ($rose(EVENTS_I.energy_present) && s_reg.mask[ENERGY_BIT])
            |=> s_reg.flags[ENERGY_BIT]
    ) else $error("energy event not latched");

    a_aneg_event: assert property (
        ($rose(EVENTS_I.autoneg_done) && s_reg.mask[ANEG_DONE_BIT])
            |=> s_reg.flags[ANEG_DONE_BIT]
    ) else $error("autoneg done not latched");

    a_rfault_event: assert property (
        ($rose(EVENTS_I.remote_fault) && s_reg.mask[RFAULT_BIT])
            |=> s_reg.flags[RFAULT_BIT]
    ) else $error("remote fault not latched");

    a_link_down_event: assert property (
        ($fell(EVENTS_I.link_up) && s_reg.mask[LINK_DOWN_BIT])
            |=> s_reg.flags[LINK_DOWN_BIT]
    ) else $error("link down not latched");

    a_ack_event: assert property (
        ($rose(EVENTS_I.partner_ack) && s_reg.mask[ACK_BIT])
            |=> s_reg.flags[ACK_BIT]
    ) else $error("partner ack not latched");

    a_pdf_event: assert property (
        ($rose(EVENTS_I.parallel_fault) && s_reg.mask[PDF_BIT])
            |=> s_reg.flags[PDF_BIT]
    ) else $error("parallel fault not latched");

    a_page_event: assert property (
        ($rose(EVENTS_I.page_received) && s_reg.mask[PAGE_BIT])
            |=> s_reg.flags[PAGE_BIT]
    ) else $error("page received not latched");

    a_mask_write: assert property (
        wr_mask |=> (s_reg.mask == $past(WDATA_I[FLAG_MSB:FLAG_LSB]))
    ) else $error("mask write not stored");

    a_mask_reset_zero: assert property (
        $rose(RSTN_I) |-> (s_reg.mask == 7'h00)
    ) else $error("mask not zero after reset");

    a_irq_clear_read: assert property (
        (rd_src && !(|set_vec) && !wr_mask) |=> !IRQ_O
    ) else $error("interrupt stayed high after read");

    a_irq_on_enabled: assert property (
        ((|set_vec) && !wr_mask) |=> IRQ_O
    ) else $error("interrupt missing for enabled flag");

    a_reserved_zero: assert property (
        (rd_src || rd_mask) |=>
            ((RDATA_O[15:8] == 8'h00) && !RDATA_O[0])
    ) else $error("reserved bits read non-zero");

    a_port_reset_clear: assert property (
        (rst_req && s_reg.soft_rst) |=>
            (!s_reg.xo_en && !s_reg.xo_state && PORT_RST_O)
    ) else $error("reset-only bits not cleared");

    a_port_reset_gated: assert property (
        (rst_req && !s_reg.soft_rst) |=>
            ((s_reg.xo_en == $past(s_reg.xo_en))
             && (s_reg.xo_state == $past(s_reg.xo_state)))
    ) else $error("reset-only bits cleared without soft reset");

    a_xover_manual: assert property (
        (s_reg.xo_ovr && !s_reg.xo_en) |=>
            (XOVER_MODE_O == ($past(s_reg.xo_state)
                              ? XO_CROSS : XO_STRAIGHT))
    ) else $error("manual crossover decode wrong");

    a_xover_auto: assert property (
        (s_reg.xo_ovr && s_reg.xo_en && !s_reg.xo_state)
            |=> (XOVER_MODE_O == XO_AUTO)
    ) else $error("auto crossover decode wrong");

    a_xover_strap: assert property (
        (!s_reg.xo_ovr && s_reg.strap_s2.strap_auto)
            |=> (XOVER_MODE_O == XO_AUTO)
    ) else $error("strap not used without override");

    a_xover_cross: assert property (
        (s_reg.xo_ovr && !s_reg.xo_en && s_reg.xo_state)
            |=> (XOVER_MODE_O == XO_CROSS)
    ) else $error("manual cross decode wrong");

    a_mode_onehot: assert property (
        $onehot(XOVER_MODE_O)
    ) else $error("crossover mode not one-hot");

    a_strap_cross: assert property (
        (!s_reg.xo_ovr && !s_reg.strap_s2.strap_auto
         && s_reg.strap_s2.strap_cross) |=> (XOVER_MODE_O == XO_CROSS)
    ) else $error("cross strap not used without override");

    a_strap_straight: assert property (
        (!s_reg.xo_ovr && !s_reg.strap_s2.strap_auto
         && !s_reg.strap_s2.strap_cross) |=> (XOVER_MODE_O == XO_STRAIGHT)
    ) else $error("straight strap not used without override");

    a_port_rst_pulse: assert property (
        rst_req |=> PORT_RST_O
    ) else $error("port reset pulse missing");

    a_port_rst_single: assert property (
        !rst_req |=> !PORT_RST_O
    ) else $error("port reset pulse without request");

    a_soft_rst_clear: assert property (
        (rst_req && s_reg.soft_rst) |=> !s_reg.soft_rst
    ) else $error("soft reset bit not cleared");

    a_override_kept: assert property (
        rst_req |=> $stable(s_reg.xo_ovr)
    ) else $error("override changed by port reset");

    a_mask_stable: assert property (
        !wr_mask |=> $stable(s_reg.mask)
    ) else $error("mask changed without a write");

    a_irq_needs_flag: assert property (
        IRQ_O |-> (|s_reg.flags)
    ) else $error("interrupt high with no flag set");

    a_rdata_idle: assert property (
        !RD_I |=> (RDATA_O == DATA_ZERO)
    ) else $error("read data not zero outside a read");

    a_link_rise_quiet: assert property (
        ($rose(EVENTS_I.link_up) && !s_reg.flags[LINK_DOWN_BIT])
            |=> !s_reg.flags[LINK_DOWN_BIT]
    ) else $error("link up set the link down flag");

    a_aneg_fall_quiet: assert property (
        ($fell(EVENTS_I.autoneg_done) && !s_reg.flags[ANEG_DONE_BIT])
            |=> !s_reg.flags[ANEG_DONE_BIT]
    ) else $error("autoneg fall set the done flag");

    a_masked_page_drop: assert property (
        (!s_reg.mask[PAGE_BIT] && !s_reg.flags[PAGE_BIT])
            |=> !s_reg.flags[PAGE_BIT]
    ) else $error("masked page event latched");

    c_read_with_flag: cover property (
        rd_src && (|s_reg.flags)
    );

    c_irq_rises: cover property (
        $rose(IRQ_O)
    );

    c_port_reset_clear: cover property (
        rst_req && s_reg.soft_rst && s_reg.xo_en
    );

    c_set_during_read: cover property (
        rd_src && (|set_vec)
    );

    c_auto_mode: cover property (
        s_reg.xo_ovr && (XOVER_MODE_O == XO_AUTO)
    );
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench for the PHY interrupt and crossover block
// Assumes: Register strobes launched by NBA right after a rising edge
// Notes:   Expected values come from the register map and bit positions
`timescale 1ns/1ps
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module testbench;
    import phy_irq_pkg::*;
    // ==========================================================
    // Signals and design
    logic clk;
    logic rstn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [DATA_W-1:0] rdata;
    phy_events_t events;
    xover_strap_t strap;
    logic irq;
    logic port_rst;
    xover_mode_t xmode;
    int mismatches = 0;
    int num_checks = 0;
    logic [15:0] xo_data [3] = '{16'h8000, 16'hA000, 16'hC000};
    xover_mode_t xo_mode [3] = '{XO_STRAIGHT, XO_CROSS, XO_AUTO};

    phy_irq_flags_and_crossover_ctrl u_dut (
        .CLK_I(clk),
        .RSTN_I(rstn),
        .ADDR_I(addr),
        .WDATA_I(wdata),
        .WR_I(wr_en),
        .RD_I(rd_en),
        .RDATA_O(rdata),
        .EVENTS_I(events),
        .STRAP_I(strap),
        .IRQ_O(irq),
        .PORT_RST_O(port_rst),
        .XOVER_MODE_O(xmode)
    );

    // ==========================================================
    // Clock, bus tasks and closing
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic reg_read(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] got;
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        got = rdata;
        `CHK(got, e)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Toggles status bits for one cycle, then restores them
    task automatic pulse(input logic [6:0] bits);
        @(posedge clk);
        events <= phy_events_t'(events ^ bits);
        @(posedge clk);
        events <= phy_events_t'(events ^ bits);
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    // ==========================================================
    // Test sequence
    initial begin
        rstn = 1'b0;
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        events = phy_events_t'(7'h08);
        strap = '0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        tick(4);
        `CHK(irq, 1'b0)
        `CHK(xmode, XO_STRAIGHT)
        reg_read(REG_MASK_IDX, 16'h0000);
        reg_read(REG_SRC_IDX, 16'h0000);
        reg_read(5'h05, 16'h0000);
        reg_write(REG_MASK_IDX, 16'hFFFF);
        reg_read(REG_MASK_IDX, 16'h00FE);
        reg_write(REG_SRC_IDX, 16'hFFFF);
        reg_read(REG_SRC_IDX, 16'h0000);
        // Each source alone: masked, then enabled
        for (int k = 1; k <= 7; k++) begin
            reg_write(REG_MASK_IDX, 16'h00FE ^ (16'h0001 << k));
            pulse(7'h01 << (k - 1));
            tick(3);
            `CHK(irq, 1'b0)
            reg_read(REG_SRC_IDX, 16'h0000);
            reg_write(REG_MASK_IDX, 16'hFFFF);
            pulse(7'h01 << (k - 1));
            tick(3);
            `CHK(irq, 1'b1)
            reg_read(REG_SRC_IDX, 16'h0001 << k);
            tick(1);
            `CHK(irq, 1'b0)
            reg_read(REG_SRC_IDX, 16'h0000);
        end
        // All sources, then mask gating of latched flags
        pulse(7'h7F);
        tick(3);
        `CHK(irq, 1'b1)
        reg_write(REG_MASK_IDX, 16'h0000);
        tick(2);
        `CHK(irq, 1'b0)
        reg_write(REG_MASK_IDX, 16'h00FE);
        tick(2);
        `CHK(irq, 1'b1)
        reg_read(REG_SRC_IDX, 16'h00FE);
        reg_read(REG_SRC_IDX, 16'h0000);
        // Crossover decode under override
        for (int i = 0; i < 3; i++) begin
            reg_write(REG_XOVER_IDX, xo_data[i]);
            tick(3);
            `CHK(xmode, xo_mode[i])
            reg_read(REG_XOVER_IDX, xo_data[i]);
        end
        // Straps rule without override
        reg_write(REG_XOVER_IDX, 16'h4000);
        @(posedge clk);
        strap <= '{strap_auto: 1'b0, strap_cross: 1'b1};
        tick(6);
        `CHK(xmode, XO_CROSS)
        @(posedge clk);
        strap <= '{strap_auto: 1'b1, strap_cross: 1'b0};
        tick(6);
        `CHK(xmode, XO_AUTO)
        @(posedge clk);
        strap <= '0;
        tick(6);
        `CHK(xmode, XO_STRAIGHT)
        // PHY reset without and with soft reset bit
        reg_write(REG_XOVER_IDX, 16'hC000);
        reg_write(REG_RSTCTL_IDX, 16'h0002);
        #1;
        `CHK(port_rst, 1'b1)
        tick(1);
        `CHK(port_rst, 1'b0)
        reg_read(REG_XOVER_IDX, 16'hC000);
        reg_write(REG_BASIC_IDX, 16'h8000);
        reg_read(REG_BASIC_IDX, 16'h8000);
        reg_write(REG_RSTCTL_IDX, 16'h0002);
        reg_read(REG_XOVER_IDX, 16'h8000);
        reg_read(REG_BASIC_IDX, 16'h0000);
        reg_read(REG_RSTCTL_IDX, 16'h0000);
        tick(3);
        `CHK(xmode, XO_STRAIGHT)
        reg_read(REG_MASK_IDX, 16'h00FE);
        // Mid-run reset with a flag pending
        pulse(7'h01);
        tick(2);
        `CHK(irq, 1'b1)
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        tick(3);
        `CHK(irq, 1'b0)
        `CHK(xmode, XO_STRAIGHT)
        reg_read(REG_MASK_IDX, 16'h0000);
        reg_read(REG_SRC_IDX, 16'h0000);
        reg_read(REG_XOVER_IDX, 16'h0000);
        complete_run();
    end
endmodule
